/* hw/cpu_event_pkg.sv */
// Package with register map, field layout and bus types of the event controller
package cpu_event_pkg;
    localparam int EVENT_COUNT = 8;
    localparam int GROUP_SIZE = 4;
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    // Byte addresses of the word-aligned registers
    localparam logic [ADDR_WIDTH-1:0] OFFS_PENDING = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] OFFS_ENABLE = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] OFFS_TOP_CODE = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] OFFS_SUMMARY = 4'hc;
    // Reset values
    localparam logic [7:0] RESET_PENDING = 8'h00;
    localparam logic [7:0] RESET_ENABLE = 8'h00;
    localparam logic [7:0] NONE_PENDING_CODE = 8'hff;
    localparam logic [7:0] RESET_SUMMARY = 8'h00;
    // Summary field positions
    localparam int SUMMARY_HIGH_BIT = 1;
    localparam int SUMMARY_LOW_BIT = 0;
    // Answer given to an unmapped address
    localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 32'h00000000;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] address;
        logic read;
        logic write;
        logic [DATA_WIDTH-1:0] writedata;
        logic [3:0] byteenable;
    } avalon_req_t;

    // Derived view of the pending flags
    typedef struct packed {
        logic [7:0] topCode;
        logic highGroup;
        logic lowGroup;
    } event_view_t;
endpackage

/* hw/event_edge_catch.sv */
// Rising-edge detector per event source, gated by the enable mask
`timescale 1ns/1ps
`default_nettype none
module event_edge_catch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] sourceLine,
    input wire logic [WIDTH-1:0] enableMask,
    output logic [WIDTH-1:0] risePulse
);
    logic [WIDTH-1:0] lastLine_reg;

    // Previous level, kept even while disabled so enabling never fakes an edge
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            lastLine_reg <= '0;
        else
            lastLine_reg <= sourceLine;
    end

    // Edge only counts while enabled; a masked edge is not kept for later
    assign risePulse = sourceLine & ~lastLine_reg & enableMask;
endmodule // event_edge_catch
`default_nettype wire

/* hw/event_priority_view.sv */
// Priority code and group summary derived from the latched flags
`timescale 1ns/1ps
`default_nettype none
module event_priority_view #(
    parameter int WIDTH = 8,
    parameter int GROUP = 4
) (
    input wire logic [WIDTH-1:0] pendingFlags,
    output cpu_event_pkg::event_view_t view
);
    // Highest set index wins; all ones when nothing pends
    function automatic logic [7:0] top_index(input logic [WIDTH-1:0] flags);
        logic [7:0] code;
        code = cpu_event_pkg::NONE_PENDING_CODE;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (flags[i])
                code = 8'(i);
        end
        return code;
    endfunction

    // One driver for the whole view, so the packed output never has a driver per member
    assign view = '{
        topCode: top_index(pendingFlags),
        highGroup: |pendingFlags[WIDTH-1:GROUP],
        lowGroup: |pendingFlags[GROUP-1:0]
    };
endmodule // event_priority_view
`default_nettype wire

/* hw/cpu_event_handler.sv */
// Event controller top: flags, enables, helper registers and Avalon-MM slave
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight sources form two groups of four, bits 7..4 high priority and 3..0 low.
// - An active source raises a CPU event kept in its pending flag until software clears it.
// - A flag sets only on a rising edge of its source while its enable bit is one.
// - Each enable bit is read/write and one enables the source of the same index.
// - Writing one to a flag clears it, writing zero leaves it alone.
// - Reset clears all flags and enable bits.
// - The top code register gives the highest pending index, all ones when none pends.
// - The summary register shows high-group pending in bit 1, low-group in bit 0, others zero.
// - Code and summary come from the latched flags, not the raw source lines.
// - The high group drives one CPU event input and the low group the other.
module cpu_event_handler #(
    parameter int EVENTS = cpu_event_pkg::EVENT_COUNT,
    parameter int GROUP = cpu_event_pkg::GROUP_SIZE
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [EVENTS-1:0] eventSource,
    input wire logic [cpu_event_pkg::ADDR_WIDTH-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [cpu_event_pkg::DATA_WIDTH-1:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [cpu_event_pkg::DATA_WIDTH-1:0] avsReaddata,
    output logic avsWaitrequest,
    output logic cpuEventInputA,
    output logic cpuEventInputB,
    output logic irq
);
    cpu_event_pkg::avalon_req_t req;
    cpu_event_pkg::event_view_t view;
    logic [EVENTS-1:0] risePulse;
    logic [EVENTS-1:0] eventPendingFlags_reg;
    logic [EVENTS-1:0] eventPendingFlags_next;
    logic [EVENTS-1:0] eventEnableMask_reg;
    logic [EVENTS-1:0] eventEnableMask_next;
    logic [cpu_event_pkg::DATA_WIDTH-1:0] readdata_reg;
    logic [cpu_event_pkg::DATA_WIDTH-1:0] readdata_next;
    logic answered_reg;
    logic eventA_reg;
    logic eventB_reg;
    logic irq_reg;

    // Bundle the bus request in one assignment; a packed variable takes a single driver
    assign req = '{
        address: avsAddress,
        read: avsRead,
        write: avsWrite,
        writedata: avsWritedata,
        byteenable: avsByteenable
    };

    // Edge capture per source
    event_edge_catch #(
        .WIDTH(EVENTS)
    ) edgeCatch (
        .clk(clk),
        .resetn(resetn),
        .sourceLine(eventSource),
        .enableMask(eventEnableMask_reg),
        .risePulse(risePulse)
    );

    // Code and summary from latched flags
    event_priority_view #(
        .WIDTH(EVENTS),
        .GROUP(GROUP)
    ) priorityView (
        .pendingFlags(eventPendingFlags_reg),
        .view(view)
    );

    // Address decode; one wait cycle lets read data come from a flop
    wire accessNow = (req.read | req.write) & ~answered_reg;
    wire lowLane = req.byteenable[0];
    wire hitPending = req.address == cpu_event_pkg::OFFS_PENDING;
    wire hitEnable = req.address == cpu_event_pkg::OFFS_ENABLE;
    wire hitTopCode = req.address == cpu_event_pkg::OFFS_TOP_CODE;
    wire hitSummary = req.address == cpu_event_pkg::OFFS_SUMMARY;
    wire writePending = accessNow & req.write & lowLane & hitPending;
    wire writeEnable = accessNow & req.write & lowLane & hitEnable;
    wire [EVENTS-1:0] clearMask = writePending ? req.writedata[EVENTS-1:0] : '0;

    // New edges win over a clear in the same cycle so no event is lost
    assign eventPendingFlags_next = (eventPendingFlags_reg & ~clearMask) | risePulse;
    assign eventEnableMask_next = writeEnable ? req.writedata[EVENTS-1:0] : eventEnableMask_reg;

    // Read mux; narrow registers sit in the low bits, unmapped reads zero
    wire [7:0] summaryByte = {6'h00, view.highGroup, view.lowGroup};
    assign readdata_next =
        hitPending ? {24'h000000, eventPendingFlags_reg} :
        hitEnable ? {24'h000000, eventEnableMask_reg} :
        hitTopCode ? {24'h000000, view.topCode} :
        hitSummary ? {24'h000000, summaryByte} :
        cpu_event_pkg::UNMAPPED_READ;

    // Flag and enable storage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            eventPendingFlags_reg <= cpu_event_pkg::RESET_PENDING;
            eventEnableMask_reg <= cpu_event_pkg::RESET_ENABLE;
        end
        else
        begin
            eventPendingFlags_reg <= eventPendingFlags_next;
            eventEnableMask_reg <= eventEnableMask_next;
        end
    end

    // Bus answer: one-cycle acknowledge after the request is taken
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            answered_reg <= 1'b0;
            readdata_reg <= cpu_event_pkg::UNMAPPED_READ;
        end
        else
        begin
            answered_reg <= accessNow;
            if (accessNow && req.read)
                readdata_reg <= readdata_next;
        end
    end

    // Group outputs to the CPU core and the level interrupt, all registered
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            eventA_reg <= 1'b0;
            eventB_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            eventA_reg <= view.highGroup;
            eventB_reg <= view.lowGroup;
            irq_reg <= |eventPendingFlags_reg;
        end
    end

    // Waitrequest stays high until the answer cycle; kept in a flop
    logic wait_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wait_reg <= 1'b1;
        else
            wait_reg <= ~accessNow;
    end

    assign avsWaitrequest = wait_reg;
    assign avsReaddata = readdata_reg;
    assign cpuEventInputA = eventA_reg;
    assign cpuEventInputB = eventB_reg;
    assign irq = irq_reg;
endmodule // cpu_event_handler
`default_nettype wire

/* verif/cpu_event_handler_assertions.sv */
// Port checker for the event controller
`timescale 1ns/1ps
`default_nettype none
module cpu_event_handler_checker #(
    parameter int EVENTS = 8,
    parameter int GROUP = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [EVENTS-1:0] eventSource,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest,
    input wire logic cpuEventInputA,
    input wire logic cpuEventInputB,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic req = avsRead || avsWrite;
    wire logic rdAck = avsRead && !avsWaitrequest;
    // Bus answers come one cycle after the take and last one cycle
    a_ack_next: assert property (req && avsWaitrequest |=> !avsWaitrequest) else $error("late ack");
    a_ack_single: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("long ack");
    a_idle_wait: assert property (!req |=> avsWaitrequest) else $error("ack w/o request");
    a_irq_any: assert property (irq == (cpuEventInputA || cpuEventInputB)) else $error("irq mismatch");
    // A group output may only rise two edges after a source edge
    a_high_cause: assert property ($rose(cpuEventInputA) |-> |($past(eventSource[EVENTS-1:GROUP], 2)
        & ~$past(eventSource[EVENTS-1:GROUP], 3))) else $error("high rise w/o edge");
    a_low_cause: assert property ($rose(cpuEventInputB) |-> |($past(eventSource[GROUP-1:0], 2)
        & ~$past(eventSource[GROUP-1:0], 3))) else $error("low rise w/o edge");
    a_summary_read: assert property (rdAck && avsAddress == 4'hc |->
        avsReaddata == {30'h0, cpuEventInputA, cpuEventInputB}) else $error("bad summary");
    a_top_read: assert property (rdAck && avsAddress == 4'h8 |-> (!irq ? avsReaddata == 32'hff :
        cpuEventInputA ? avsReaddata inside {[4:7]} : avsReaddata < 4)) else $error("bad top code");
    c_high: cover property ($rose(cpuEventInputA));
    c_low: cover property ($rose(cpuEventInputB));
    c_clear: cover property (avsWrite && !avsWaitrequest && avsAddress == 4'h0);
endmodule // cpu_event_handler_checker
bind cpu_event_handler cpu_event_handler_checker #(.EVENTS(EVENTS), .GROUP(GROUP)) i_checker (
    .clk(clk), .resetn(resetn), .eventSource(eventSource), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .cpuEventInputA(cpuEventInputA), .cpuEventInputB(cpuEventInputB), .irq(irq));
`default_nettype wire

/* verif/event_source_model.sv */
// Peripheral event sources feeding the controller
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
    input wire logic clk,
    input wire logic [7:0] level,
    output logic [7:0] srcLine = 8'h00
);
    // Synchronous peripherals change their lines only at a clock edge
    always_ff @(posedge clk)
    begin
        srcLine <= level;
    end
endmodule // event_source_model
`default_nettype wire

/* verif/tb_cpu_event_handler.sv */
// Self-checking bench for the event controller
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_event_handler;
    logic clk = 1'b0, resetn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic avsWaitrequest, cpuEventInputA, cpuEventInputB, irq;
    logic [3:0] avsAddress = 4'h0, avsByteenable = 4'hf;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
    logic [7:0] level = 8'h00, eventSource, en, pat, cm, fl;
    int nMismatch = 0, testsRun = 0;
    cpu_event_handler i_cpu_event_handler (.clk(clk), .resetn(resetn), .eventSource(eventSource),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .cpuEventInputA(cpuEventInputA), .cpuEventInputB(cpuEventInputB), .irq(irq));
    event_source_model i_event_source_model (.clk(clk), .level(level), .srcLine(eventSource));
    always #2 clk = ~clk;
    // Highest pending index wins, all ones when nothing pends
    function automatic logic [31:0] topCode(input logic [7:0] f);
        topCode = 32'hff;
        for (int i = 0; i < 8; i++)
            if (f[i])
                topCode = i;
    endfunction
    function automatic logic [31:0] summary(input logic [7:0] f);
        return {30'h0, |f[7:4], |f[3:0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        testsRun++;
        if (e !== s)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            nMismatch++;
        end
    endtask
    // One transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= {24'h0, d};
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 8'h00);
        chk(n, e, q);
    endtask
    task automatic endSim();
        if (nMismatch == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (8000) @(posedge clk);
        nMismatch++;
        endSim();
    end
    initial
    begin
        void'($urandom(55));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 32'h0, "pending");
        rd(4'h4, 32'h0, "enable");
        rd(4'h8, 32'hff, "top");
        rd(4'hc, 32'h0, "summary");
        bus(1'b1, 4'h8, 8'h12);
        rd(4'h8, 32'hff, "top ro");
        rd(4'h6, 32'h0, "unmapped");
        // Writes without the low byte lane or to an unmapped address must change nothing
        avsByteenable <= 4'h0;
        bus(1'b1, 4'h4, 8'hff);
        avsByteenable <= 4'hf;
        rd(4'h4, 32'h0, "lane off");
        bus(1'b1, 4'h6, 8'hff);
        rd(4'h4, 32'h0, "unmapped wr");
        // Random enables, edges and selective clears
        repeat (40)
        begin
            en = 8'($urandom);
            pat = 8'($urandom);
            cm = 8'($urandom);
            bus(1'b1, 4'h4, en);
            rd(4'h4, {24'h0, en}, "enable");
            level <= pat;
            repeat (4) @(posedge clk);
            fl = pat & en;
            rd(4'h0, {24'h0, fl}, "pending");
            rd(4'h8, topCode(fl), "top");
            rd(4'hc, summary(fl), "summary");
            chk("cpu a", 32'(|fl[7:4]), 32'(cpuEventInputA));
            chk("cpu b", 32'(|fl[3:0]), 32'(cpuEventInputB));
            chk("irq", 32'(|fl), 32'(irq));
            bus(1'b1, 4'h0, cm);
            fl = fl & ~cm;
            // Enabling while lines are already high must add nothing
            bus(1'b1, 4'h4, 8'hff);
            level <= 8'h00;
            repeat (4) @(posedge clk);
            rd(4'h0, {24'h0, fl}, "kept");
            rd(4'hc, summary(fl), "latched");
            bus(1'b1, 4'h0, 8'hff);
            rd(4'h0, 32'h0, "cleared");
        end
        // Reset in mid-run with flags and enables set must clear both
        bus(1'b1, 4'h4, 8'h5a);
        level <= 8'hff;
        repeat (4) @(posedge clk);
        rd(4'h0, 32'h5a, "pre-reset");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 32'h0, "pending rst");
        rd(4'h4, 32'h0, "enable rst");
        rd(4'h8, 32'hff, "top rst");
        rd(4'hc, 32'h0, "summary rst");
        chk("irq rst", 32'h0, 32'(irq));
        chk("cpu a rst", 32'h0, 32'(cpuEventInputA));
        chk("cpu b rst", 32'h0, 32'(cpuEventInputB));
        endSim();
    end
endmodule // tb_cpu_event_handler
`default_nettype wire
